// ### core/mebc_bus_ctrl.sv
/*
 * External multiplexed bus control: address strobe, data strobe,
 * read/write direction, opcode fetch flag and the shared bus lines.
 * Assumes the core presents one access per bus cycle on core_* ports,
 * holding it until core_ack_o, and reads pwr_mode_i for wait/stop.
 */
// Functional notes
// R1: reset low returns all state to initial
// R2: interrupt input is level and edge sensitive
// R3: fetch flag high during next opcode fetch
// R4: fetch flag overlaps that cycle's data strobe
// R5: data strobe on every read or write
// R6: strobe at clock over five, not wait/stop
// R7: direction high read, low write, before strobe
// R8: direction shown for internal and external accesses
// R9: address strobe marks low address on bus
// R10: shared lines carry address then data
// R11: upper five address lines driven dedicated
// R12: strobes held inactive in wait and stop
`timescale 1ns/1ps
module mebc_bus_ctrl
    import mebc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] pwr_mode_i,
    input wire logic core_req_i,
    input wire logic core_rd_i,
    input wire logic core_fetch_i,
    input wire logic [12:0] core_addr_i,
    input wire logic [7:0] core_wdata_i,
    output logic core_ack_o,
    output logic [7:0] core_rdata_o,
    input wire logic irq_n_i,
    input wire logic irq_ack_i,
    output logic irq_pend_o,
    output logic addr_latch_strobe_o,
    output logic transfer_strobe_o,
    output logic rd_wr_n_o,
    output logic opcode_fetch_flag_o,
    output logic [4:0] upper_addr_lines_o,
    input wire logic [7:0] shared_addr_data_lines_i,
    output logic [7:0] shared_addr_data_lines_o,
    output logic [7:0] shared_addr_data_lines_oe_o
);
    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0; // see R1
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // ---------------------------------------------------------------
    // interrupt sensing
    // ---------------------------------------------------------------
    assign rst_n = rst_s2_ff; // see R1

    mebc_irq_sense u_irq (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .irq_n_i(irq_n_i),
        .irq_ack_i(irq_ack_i),
        .irq_pend_o(irq_pend_o)
    );

    // ---------------------------------------------------------------
    // phase counter and decode
    // ---------------------------------------------------------------
    // data strobe window of a phase, shared by strobe and bus enable decode
    function automatic logic in_ds_window(input logic [2:0] ph);
        return (ph >= MEBC_PH_DS_START) && (ph <= MEBC_PH_DS_END);
    endfunction

    logic [2:0] phase_ff;
    logic [2:0] nxt_phase;
    logic halted;
    logic ph_ds_last;
    logic ph_end;

    assign halted = (pwr_mode_i == MEBC_WAIT) | (pwr_mode_i == MEBC_STOP);
    assign ph_end = (phase_ff == MEBC_PH_LAST);
    // wait or stop parks the counter; the resumed cycle has no address strobe
    assign nxt_phase = halted ? MEBC_PH_RST : (ph_end ? MEBC_PH_RST : phase_ff + 3'h1); // see R6
    assign ph_ds_last = ~halted & (phase_ff == MEBC_PH_DS_END);

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            phase_ff <= MEBC_PH_RST;
        else
            phase_ff <= nxt_phase;
    end

    // ---------------------------------------------------------------
    // cycle capture at the start of each bus cycle
    // ---------------------------------------------------------------
    logic cyc_start;
    logic cyc_rd_ff;
    logic cyc_fetch_ff;
    logic cyc_act_ff;
    logic [12:0] cyc_addr_ff;
    logic [7:0] cyc_wdata_ff;
    logic [7:0] rdata_ff;
    logic ack_ff;

    assign cyc_start = ~halted & ph_end;

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_rd_ff <= MEBC_RW_RST;
            cyc_fetch_ff <= 1'b0;
            cyc_act_ff <= 1'b0;
            cyc_addr_ff <= MEBC_ADDR_RST;
            cyc_wdata_ff <= MEBC_DATA_RST;
        end
        else if (cyc_start)
        begin
            cyc_act_ff <= core_req_i;
            // idle cycles still strobe; they look like a read
            cyc_rd_ff <= core_req_i ? core_rd_i : 1'b1; // see R7, R8
            cyc_fetch_ff <= core_req_i & core_fetch_i & core_rd_i; // see R3
            cyc_addr_ff <= core_req_i ? core_addr_i : cyc_addr_ff;
            cyc_wdata_ff <= core_wdata_i;
        end
    end

    // read data captured at the data strobe trailing phase
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff <= MEBC_DATA_RST;
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= cyc_act_ff & ph_ds_last;
            if (cyc_act_ff & cyc_rd_ff & ph_ds_last)
                rdata_ff <= shared_addr_data_lines_i;
        end
    end

    assign core_ack_o = ack_ff;
    assign core_rdata_o = rdata_ff;

    // ---------------------------------------------------------------
    // registered pin outputs
    // ---------------------------------------------------------------
    logic as_ff;
    logic ds_ff;
    logic li_ff;
    logic [7:0] bus_out_ff;
    logic bus_oe_ff;
    logic nxt_as;
    logic nxt_ds;
    logic nxt_li;
    logic [2:0] next_ph_q;
    logic nxt_oe;
    logic [7:0] nxt_bus;
    logic nxt_is_as;
    logic nxt_is_ds;

    assign next_ph_q = nxt_phase;
    assign nxt_is_as = ~halted & (next_ph_q == MEBC_PH_AS) & ~(phase_ff == MEBC_PH_RST & ~ph_end);
    assign nxt_is_ds = ~halted & in_ds_window(next_ph_q);
    assign nxt_as = nxt_is_as; // see R9, R12
    assign nxt_ds = nxt_is_ds; // see R5, R6, R12
    // flag spans the whole fetch cycle, covering its data strobe
    assign nxt_li = ~halted & (cyc_start ? (core_req_i & core_fetch_i & core_rd_i)
                                          : cyc_fetch_ff); // see R3, R4
    // address phase drives low address, write data phase drives data
    // an idle cycle repeats the held address, so it matches the upper lines
    assign nxt_bus = (next_ph_q < MEBC_PH_DS_START) ?
                     ((cyc_start & core_req_i) ? core_addr_i[7:0] : cyc_addr_ff[7:0]) : cyc_wdata_ff; // see R10
    assign nxt_oe = ~halted & ((next_ph_q < MEBC_PH_DS_START) |
                    (~cyc_rd_ff & in_ds_window(next_ph_q))); // see R10, R7

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            as_ff <= 1'b0;
            ds_ff <= 1'b0;
            li_ff <= 1'b0;
            bus_out_ff <= MEBC_DATA_RST;
            bus_oe_ff <= 1'b0;
        end
        else
        begin
            as_ff <= nxt_as;
            ds_ff <= nxt_ds;
            li_ff <= nxt_li;
            bus_out_ff <= nxt_bus;
            bus_oe_ff <= nxt_oe;
        end
    end

    assign addr_latch_strobe_o = as_ff;
    assign transfer_strobe_o = ds_ff;
    assign opcode_fetch_flag_o = li_ff;
    assign rd_wr_n_o = cyc_rd_ff; // see R7, R8
    assign upper_addr_lines_o = cyc_addr_ff[12:8]; // see R11
    assign shared_addr_data_lines_o = bus_out_ff;
    assign shared_addr_data_lines_oe_o = {MEBC_LOW_ADDR_W{bus_oe_ff}};

endmodule // mebc_bus_ctrl

// ### core/mebc_irq_sense.sv
/*
 * Interrupt request sensing: synchronises the active-low request pin
 * and reports a pending request on a falling edge or a held low level.
 * Assumes the pin is asynchronous to sys_clk_i.
 */
`timescale 1ns/1ps
module mebc_irq_sense
    import mebc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic irq_n_i,
    input wire logic irq_ack_i,
    output logic irq_pend_o
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic edge_ff;
    logic nxt_edge;
    logic fall;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff <= 1'b1;
            edge_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= irq_n_i;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            edge_ff <= nxt_edge;
        end
    end

    assign fall = prev_ff & ~sync2_ff;
    // edge latch: a new edge wins over the acknowledge
    assign nxt_edge = fall | (edge_ff & ~irq_ack_i); // see R2
    assign irq_pend_o = edge_ff | ~sync2_ff; // see R2
endmodule // mebc_irq_sense

// ### core/mebc_pkg.sv
/*
 * Package for the external bus control block: bus cycle phases,
 * widths and cycle counts.
 * Assumes a single 100 MHz system clock acting as the oscillator.
 */
package mebc_pkg;
    // -------------------------------------------------------------
    // widths
    // -------------------------------------------------------------
    localparam int MEBC_LOW_ADDR_W = 8;
    localparam int MEBC_HIGH_ADDR_W = 5;
    localparam int MEBC_ADDR_W = 13;
    // -------------------------------------------------------------
    // strobe timing: one bus cycle is five oscillator cycles
    // -------------------------------------------------------------
    localparam int MEBC_CLK_PERIOD_NS = 10;
    localparam int MEBC_OSC_DIV = 5;
    localparam logic [2:0] MEBC_PH_LAST = 3'h4;
    localparam logic [2:0] MEBC_PH_AS = 3'h0;
    localparam logic [2:0] MEBC_PH_DS_START = 3'h2;
    localparam logic [2:0] MEBC_PH_DS_END = 3'h3;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [2:0] MEBC_PH_RST = 3'h0;
    localparam logic MEBC_RW_RST = 1'b1;
    localparam logic [12:0] MEBC_ADDR_RST = 13'h0000;
    localparam logic [7:0] MEBC_DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        MEBC_RUN,
        MEBC_WAIT,
        MEBC_STOP
    } mebc_pwr_t;
endpackage

// ### verif/mebc_bus_checker.sv
/* bus strobe, direction and fetch flag assertions for mebc_bus_ctrl.
   assumes one clock and the async active-low reset of the block. */
`timescale 1ns/1ps
module mebc_bus_checker
    import mebc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] pwr_mode_i,
    input wire logic core_rd_i,
    input wire logic [12:0] core_addr_i,
    input wire logic core_ack_o,
    input wire logic addr_latch_strobe_o,
    input wire logic transfer_strobe_o,
    input wire logic rd_wr_n_o,
    input wire logic opcode_fetch_flag_o,
    input wire logic [4:0] upper_addr_lines_o
);
    wire logic run_w = !(pwr_mode_i inside {2'h1, 2'h2});
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    ds_shape_a: assert property (addr_latch_strobe_o && run_w ##1 run_w [*2] |->
        !$past(transfer_strobe_o, 2) && !$past(transfer_strobe_o) && transfer_strobe_o
        ##1 transfer_strobe_o ##1 !transfer_strobe_o) else $error("data strobe shape wrong");
    as_spacing_a: assert property (addr_latch_strobe_o |=> !addr_latch_strobe_o [*4]) else $error("strobe too close");
    strobe_rate_a: assert property (addr_latch_strobe_o && run_w ##1 run_w [*4] |=> addr_latch_strobe_o)
        else $error("strobe not every five cycles");
    quiet_low_a: assert property (!run_w [*7] |-> !addr_latch_strobe_o && !transfer_strobe_o)
        else $error("strobe in wait or stop");
    fetch_overlap_a: assert property (addr_latch_strobe_o && opcode_fetch_flag_o && run_w
        ##1 run_w [*2] |-> $past(opcode_fetch_flag_o) && opcode_fetch_flag_o && transfer_strobe_o
        ##1 opcode_fetch_flag_o && transfer_strobe_o) else $error("fetch flag misses strobe");
    fetch_read_a: assert property (opcode_fetch_flag_o |-> rd_wr_n_o) else $error("fetch flag on write");
    dir_match_a: assert property (core_ack_o |-> $past(rd_wr_n_o) == $past(core_rd_i) &&
        $past(upper_addr_lines_o) == $past(core_addr_i[12:8])) else $error("direction or address wrong");
    rw_hold_a: assert property (addr_latch_strobe_o |=> $stable(rd_wr_n_o) [*4]) else $error("direction moved");
endmodule // mebc_bus_checker

bind mebc_bus_ctrl mebc_bus_checker u_chk (.sys_clk_i, .rstn_i, .pwr_mode_i, .core_rd_i, .core_addr_i, .core_ack_o,
    .addr_latch_strobe_o, .transfer_strobe_o, .rd_wr_n_o, .opcode_fetch_flag_o, .upper_addr_lines_o);

// ### verif/mebc_ext_mem.sv
/* external memory on the shared lines; resolves the wire level.
   assumes device drives lines only where its enable is high. */
`timescale 1ns/1ps
module mebc_ext_mem
(
    input wire logic sys_clk_i,
    input wire logic as_i,
    input wire logic ds_i,
    input wire logic rw_i,
    input wire logic [4:0] upper_i,
    input wire logic [7:0] dev_i,
    input wire logic [7:0] oe_i,
    output logic [7:0] bus_o
);
    logic [7:0] mem_ff [0:8191];
    logic [12:0] addr_ff;
    logic [7:0] last_ff = 8'h00;
    // released lines toggle so stale data never looks valid
    wire logic [7:0] drv_w = (ds_i && rw_i) ? mem_ff[addr_ff] : ~last_ff;
    assign bus_o = (oe_i & dev_i) | (~oe_i & drv_w);
    always @(posedge sys_clk_i)
    begin
        last_ff <= bus_o;
        if (as_i)
            addr_ff <= {upper_i, bus_o};
        if (ds_i && !rw_i && oe_i == 8'hff)
            mem_ff[addr_ff] <= bus_o;
    end
endmodule // mebc_ext_mem

// ### verif/tb_top.sv
/* self-checking bench for mebc_bus_ctrl with an external memory model.
   assumes 100 MHz clock; next request goes out as the data strobe ends. */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rstn = 1'b0, req = 1'b0, rd = 1'b1, fet = 1'b0, irqn = 1'b1, iack = 1'b0, ds_q = 1'b0;
    logic [1:0] pwr = 2'h0;
    logic [12:0] adr = 13'h0000;
    logic [7:0] wd = 8'h00, n_as;
    logic ack, pend, as_w, ds_w, rw_w, flg;
    logic [7:0] rdat, b_i, b_o, b_oe;
    logic [4:0] up;
    logic [22:0] stim_q [$];
    logic [22:0] s_n;
    logic [8:0] exp_q [$];
    logic [8:0] e_n;
    int fail_count = 0, compares = 0, cycles = 0;
    always #5 clk = ~clk;
    mebc_bus_ctrl u_dut (.sys_clk_i(clk), .rstn_i(rstn), .pwr_mode_i(pwr), .core_req_i(req), .core_rd_i(rd),
        .core_fetch_i(fet), .core_addr_i(adr), .core_wdata_i(wd), .core_ack_o(ack), .core_rdata_o(rdat),
        .irq_n_i(irqn), .irq_ack_i(iack), .irq_pend_o(pend), .addr_latch_strobe_o(as_w), .transfer_strobe_o(ds_w),
        .rd_wr_n_o(rw_w), .opcode_fetch_flag_o(flg), .upper_addr_lines_o(up), .shared_addr_data_lines_i(b_i),
        .shared_addr_data_lines_o(b_o), .shared_addr_data_lines_oe_o(b_oe));
    mebc_ext_mem u_mem (.sys_clk_i(clk), .as_i(as_w), .ds_i(ds_w), .rw_i(rw_w), .upper_i(up), .dev_i(b_o),
        .oe_i(b_oe), .bus_o(b_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    // driver: new request lands in the ack cycle, taken at its end
    always @(posedge clk)
    begin
        ds_q <= ds_w;
        if (ds_w && ds_q)
        begin
            req <= stim_q.size() > 0;
            if (stim_q.size() > 0)
            begin
                s_n = stim_q.pop_front();
                {rd, fet, adr, wd} <= s_n;
                exp_q.push_back({s_n[22], s_n[7:0]});
            end
        end
    end
    always @(posedge clk)
        if (ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(8'h01, 8'h00);
            else
            begin
                e_n = exp_q.pop_front();
                if (e_n[8])
                    chk(rdat, e_n[7:0]);
            end
        end
    task automatic do_reset();
        @(posedge clk) rstn <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({3'h0, as_w, ds_w, rw_w, flg, b_oe[0]}, 8'h04);
        @(posedge clk) rstn <= 1'b1;
    endtask
    task automatic traffic(input int n);
        logic [12:0] a;
        logic [7:0] d;
        for (int i = 0; i < n; i++)
        begin
            a = $urandom;
            d = $urandom;
            stim_q.push_back({2'b00, a, d});
            stim_q.push_back({1'b1, i[0], a, d});
        end
        while (stim_q.size() + exp_q.size() > 0)
            @(posedge clk);
        repeat (10) @(posedge clk);
    endtask
    task automatic irq_step(input logic n, input logic k, input logic exp);
        @(posedge clk) irqn <= n;
        iack <= k;
        @(posedge clk) iack <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk({7'h0, pend}, {7'h0, exp});
    endtask
    initial
    begin
        void'($urandom(69725));
        do_reset();
        traffic(24);
        for (int m = 1; m < 4; m++)
        begin
            @(posedge clk) pwr <= m[1:0];
            n_as = 8'h00;
            repeat (10) @(posedge clk);
            repeat (30) @(posedge clk) n_as += as_w;
            chk(n_as, m == 3 ? 8'h06 : 8'h00);
        end
        do_reset();
        traffic(8);
        irq_step(1'b0, 1'b0, 1'b1);
        irq_step(1'b0, 1'b1, 1'b1);
        irq_step(1'b1, 1'b0, 1'b0);
        irq_step(1'b0, 1'b0, 1'b1);
        irq_step(1'b1, 1'b0, 1'b1);
        irq_step(1'b1, 1'b1, 1'b0);
        close_out();
    end
endmodule // tb_top
